// >>> cmlse_core.sv
// Executor for a move/logic subset of a 14-bit instruction set.
// Assumes an external register file read combinationally at mem_addr,
// written on mem_wr_en, and an external stack that pops on stack_pop.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Load-literal puts the 8-bit literal in the accumulator; flags unchanged.
// - OR accumulator with register; target bit picks destination; zero flag updated.
// - Store copies accumulator into addressed register; flags unchanged.
// - Copy-memory moves register to accumulator or back to itself; zero updated.
// - Copy back to itself leaves register as is but still sets zero.
// - Rotate left through carry; old carry to bit 0, bit 7 to carry.
module cmlse_core (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Instruction handshake
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  output logic instr_ready,
  output logic instr_done,
  output logic instr_unsupported,
  // Register file
  output logic [6:0] mem_addr,
  input wire logic [7:0] mem_rd_data,
  output logic mem_wr_en,
  output logic [7:0] mem_wr_data,
  // Stack
  input wire logic [12:0] stack_top,
  output logic stack_pop,
  // Core state
  output logic [7:0] acc,
  output logic carry_flag,
  output logic zero_flag,
  output logic [12:0] prog_counter,
  output logic global_irq_allow
);

  // ****************************************
  // State
  // ****************************************
  cmlse_pkg::cmlse_state_t state_r, state_nxt;
  logic [13:0] instr_r, instr_nxt;
  logic [6:0] addr_r, addr_nxt;
  logic ready_r, ready_nxt;
  logic done_r, done_nxt;
  logic unsup_r, unsup_nxt;
  logic wr_en_r, wr_en_nxt;
  logic [7:0] wr_data_r, wr_data_nxt;
  logic pop_r, pop_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic carry_r, carry_nxt;
  logic zero_r, zero_nxt;
  logic [12:0] pc_r, pc_nxt;
  logic gie_r, gie_nxt;
  cmlse_pkg::cmlse_op_t op_class;
  logic to_mem;
  logic [7:0] result;

  // ****************************************
  // Helpers
  // ****************************************
  // Zero test shared by the OR and copy paths
  function automatic logic is_zero(input logic [7:0] value);
    is_zero = (value == cmlse_pkg::ZERO_BYTE);
  endfunction

  // Classify the latched word
  cmlse_decode u_decode (
    .instr_word(instr_r),
    .op_class(op_class)
  );

  assign to_mem = instr_r[cmlse_pkg::DEST_BIT];

  // ****************************************
  // Next-state logic
  // ****************************************
  // Two cycles per instruction: latch and present the address, then execute.
  // Costs a cycle but keeps the register-file address straight off a flop.
  always_comb begin
    // Pulses default low, so each stands for exactly one cycle
    state_nxt = state_r;
    instr_nxt = instr_r;
    addr_nxt = addr_r;
    ready_nxt = ready_r;
    done_nxt = 1'b0;
    unsup_nxt = 1'b0;
    wr_en_nxt = 1'b0;
    wr_data_nxt = wr_data_r;
    pop_nxt = 1'b0;
    acc_nxt = acc_r;
    carry_nxt = carry_r;
    zero_nxt = zero_r;
    pc_nxt = pc_r;
    gie_nxt = gie_r;
    result = cmlse_pkg::ZERO_BYTE;
    unique case (state_r)
      cmlse_pkg::ST_ACCEPT: begin
        // One word in flight; an offer while ready is low is not taken
        if (instr_valid && ready_r) begin
          instr_nxt = instr_word;
          addr_nxt = instr_word[cmlse_pkg::ADDR_LSB +: cmlse_pkg::ADDR_W];
          ready_nxt = 1'b0;
          state_nxt = cmlse_pkg::ST_EXEC;
        end
      end
      cmlse_pkg::ST_EXEC: begin
        // Ready and done rise together, so back-to-back words lose no cycle
        ready_nxt = 1'b1;
        done_nxt = 1'b1;
        state_nxt = cmlse_pkg::ST_ACCEPT;
        // Counter wraps silently at its top; no overflow is reported
        pc_nxt = pc_r + cmlse_pkg::PC_STEP;
        unique case (op_class)
          cmlse_pkg::OP_LOAD_LIT: begin
            acc_nxt = instr_r[cmlse_pkg::LIT_LSB +: cmlse_pkg::DATA_W];
          end
          cmlse_pkg::OP_OR_MEM, cmlse_pkg::OP_COPY, cmlse_pkg::OP_ROT: begin
            if (op_class == cmlse_pkg::OP_OR_MEM) begin
              result = acc_r | mem_rd_data;
              zero_nxt = is_zero(result);
            end else if (op_class == cmlse_pkg::OP_COPY) begin
              result = mem_rd_data;
              zero_nxt = is_zero(result);
            end else begin
              // Old carry enters at the bottom, old top bit leaves as carry
              result = {mem_rd_data[cmlse_pkg::MSB_BIT - 1:0], carry_r};
              carry_nxt = mem_rd_data[cmlse_pkg::MSB_BIT];
            end
            // Target bit steers the result; copy to itself rewrites the same value
            if (to_mem) begin
              wr_en_nxt = 1'b1;
              wr_data_nxt = result;
            end else begin
              acc_nxt = result;
            end
          end
          cmlse_pkg::OP_STORE: begin
            // Store leaves every flag alone
            wr_en_nxt = 1'b1;
            wr_data_nxt = acc_r;
          end
          cmlse_pkg::OP_IRET: begin
            // Stack must show its top word in this cycle; the pop follows the load
            pc_nxt = stack_top;
            pop_nxt = 1'b1;
            gie_nxt = 1'b1;
          end
          cmlse_pkg::OP_NOP: begin
            // Nothing but the counter advance
          end
          cmlse_pkg::OP_NONE: begin
            // Outside this subset: flagged, otherwise behaves as a no-operation
            unsup_nxt = 1'b1;
          end
        endcase
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  // Reset loads constants only; its release is taken as synchronous to ref_clk
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= cmlse_pkg::ST_ACCEPT;
      instr_r <= cmlse_pkg::INSTR_RST;
      addr_r <= cmlse_pkg::ADDR_RST;
      ready_r <= 1'b1;
      done_r <= 1'b0;
      unsup_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_data_r <= cmlse_pkg::ZERO_BYTE;
      pop_r <= 1'b0;
      acc_r <= cmlse_pkg::ACC_RST;
      carry_r <= 1'b0;
      zero_r <= 1'b0;
      pc_r <= cmlse_pkg::PC_RST;
      gie_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      instr_r <= instr_nxt;
      addr_r <= addr_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      unsup_r <= unsup_nxt;
      wr_en_r <= wr_en_nxt;
      wr_data_r <= wr_data_nxt;
      pop_r <= pop_nxt;
      acc_r <= acc_nxt;
      carry_r <= carry_nxt;
      zero_r <= zero_nxt;
      pc_r <= pc_nxt;
      gie_r <= gie_nxt;
    end
  end

  // ****************************************
  // Outputs, all straight from flops
  // ****************************************
  // No logic after the flops, so the outputs never glitch
  assign instr_ready = ready_r;
  assign instr_done = done_r;
  assign instr_unsupported = unsup_r;
  assign mem_addr = addr_r;
  assign mem_wr_en = wr_en_r;
  assign mem_wr_data = wr_data_r;
  assign stack_pop = pop_r;
  assign acc = acc_r;
  assign carry_flag = carry_r;
  assign zero_flag = zero_r;
  assign prog_counter = pc_r;
  assign global_irq_allow = gie_r;

endmodule // cmlse_core

`default_nettype wire

// >>> cmlse_pkg.sv
// Package for the move/logic subset executor: opcode patterns, field
// positions, widths, reset values and the sequencer states.
// Assumes a 14-bit instruction word and a 13-bit program counter.
package cmlse_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int PC_W = 13;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int LIT_LSB = 0;        // 8-bit literal, bits 7..0
  localparam int ADDR_LSB = 0;       // 7-bit register address, bits 6..0
  localparam int DEST_BIT = 7;       // Target select: 0 accumulator, 1 memory
  localparam int MSB_BIT = 7;        // Bit that leaves on a left rotate

  // ****************************************
  // Opcode patterns (mask, match)
  // ****************************************
  localparam logic [13:0] LOAD_LIT_MASK = 14'h3c00;
  localparam logic [13:0] LOAD_LIT_MATCH = 14'h3000;
  localparam logic [13:0] OR_MEM_MASK = 14'h3f00;
  localparam logic [13:0] OR_MEM_MATCH = 14'h0400;
  localparam logic [13:0] STORE_MASK = 14'h3f80;
  localparam logic [13:0] STORE_MATCH = 14'h0080;
  localparam logic [13:0] COPY_MASK = 14'h3f00;
  localparam logic [13:0] COPY_MATCH = 14'h0800;
  localparam logic [13:0] ROT_MASK = 14'h3f00;
  localparam logic [13:0] ROT_MATCH = 14'h0d00;
  localparam logic [13:0] NOP_MASK = 14'h3f9f;
  localparam logic [13:0] NOP_MATCH = 14'h0000;
  localparam logic [13:0] IRET_MASK = 14'h3fff;
  localparam logic [13:0] IRET_MATCH = 14'h0009;

  // ****************************************
  // Reset values and constants
  // ****************************************
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [12:0] PC_STEP = 13'h0001;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [6:0] ADDR_RST = 7'h00;
  localparam logic [13:0] INSTR_RST = 14'h0000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_LOAD_LIT = 3'b001,
    OP_OR_MEM = 3'b010,
    OP_STORE = 3'b011,
    OP_COPY = 3'b100,
    OP_ROT = 3'b101,
    OP_NOP = 3'b110,
    OP_IRET = 3'b111
  } cmlse_op_t;

  typedef enum logic [0:0] {
    ST_ACCEPT = 1'b0,
    ST_EXEC = 1'b1
  } cmlse_state_t;

endpackage : cmlse_pkg

// >>> cmlse_decode.sv
// Instruction classifier for the move/logic subset executor.
// Assumes a 14-bit word; purely combinational, no clock.
`timescale 1ns/1ps
`default_nettype none

module cmlse_decode (
  // Instruction in
  input wire logic [13:0] instr_word,
  // Class out
  output cmlse_pkg::cmlse_op_t op_class
);

  // ****************************************
  // Pattern match
  // ****************************************
  function automatic logic hit(input logic [13:0] w, input logic [13:0] m,
                               input logic [13:0] v);
    hit = ((w & m) == v);
  endfunction

  // Literal don't-care bits fall outside the mask, so their value is ignored
  always_comb begin
    if (hit(instr_word, cmlse_pkg::LOAD_LIT_MASK, cmlse_pkg::LOAD_LIT_MATCH)) begin
      op_class = cmlse_pkg::OP_LOAD_LIT;
    end else if (hit(instr_word, cmlse_pkg::OR_MEM_MASK, cmlse_pkg::OR_MEM_MATCH)) begin
      op_class = cmlse_pkg::OP_OR_MEM;
    end else if (hit(instr_word, cmlse_pkg::STORE_MASK, cmlse_pkg::STORE_MATCH)) begin
      op_class = cmlse_pkg::OP_STORE;
    end else if (hit(instr_word, cmlse_pkg::COPY_MASK, cmlse_pkg::COPY_MATCH)) begin
      op_class = cmlse_pkg::OP_COPY;
    end else if (hit(instr_word, cmlse_pkg::ROT_MASK, cmlse_pkg::ROT_MATCH)) begin
      op_class = cmlse_pkg::OP_ROT;
    end else if (hit(instr_word, cmlse_pkg::IRET_MASK, cmlse_pkg::IRET_MATCH)) begin
      op_class = cmlse_pkg::OP_IRET;
    end else if (hit(instr_word, cmlse_pkg::NOP_MASK, cmlse_pkg::NOP_MATCH)) begin
      op_class = cmlse_pkg::OP_NOP;
    end else begin
      op_class = cmlse_pkg::OP_NONE;
    end
  end

endmodule // cmlse_decode

`default_nettype wire

// >>> cmlse_assertions.sv
// Port-level checker for the move/logic subset executor.
// Assumes binding to cmlse_core: one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module cmlse_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Instruction side
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic instr_ready,
  input wire logic instr_done,
  // Register file and stack
  input wire logic [7:0] mem_rd_data,
  input wire logic mem_wr_en,
  input wire logic [7:0] mem_wr_data,
  input wire logic [12:0] stack_top,
  input wire logic stack_pop,
  // Core state
  input wire logic [7:0] acc,
  input wire logic carry_flag,
  input wire logic zero_flag,
  input wire logic [12:0] prog_counter,
  input wire logic global_irq_allow
);
  // ****************************************
  // Take edge and results two edges later
  // ****************************************
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  // A taken word of one opcode class
  sequence s_take(logic [13:0] m, logic [13:0] p);
    instr_valid && instr_ready && ((instr_word & m) == p);
  endsequence
  // Busy in the exec cycle, then retired and ready again
  sequence s_busy;
    !instr_ready && !instr_done;
  endsequence
  sequence s_retire;
    instr_done && instr_ready;
  endsequence

  chk_retire_timing: assert property (s_take(14'h0000, 14'h0000) |=> s_busy ##1 s_retire)
    else $error("retire timing wrong");

  chk_load_acc: assert property (s_take(14'h3c00, 14'h3000) |-> ##2
    acc == $past(instr_word[7:0], 2)) else $error("load literal result wrong");
  chk_load_flags: assert property (s_take(14'h3c00, 14'h3000) |-> ##2
    $stable(zero_flag) && $stable(carry_flag)) else $error("load literal moved a flag");
  chk_or_zero: assert property (s_take(14'h3f00, 14'h0400) |-> ##2
    zero_flag == (($past(mem_rd_data) | $past(acc)) == 8'h00)) else $error("or zero wrong");
  chk_store_data: assert property (s_take(14'h3f80, 14'h0080) |-> ##2
    mem_wr_en && mem_wr_data == acc && $stable(zero_flag)) else $error("store wrong");
  chk_copy_zero: assert property (s_take(14'h3f00, 14'h0800) |-> ##2
    zero_flag == ($past(mem_rd_data) == 8'h00)) else $error("copy zero wrong");
  chk_copy_back: assert property (s_take(14'h3f80, 14'h0880) |-> ##2
    mem_wr_en && mem_wr_data == $past(mem_rd_data)) else $error("copy back altered data");
  chk_rot_carry: assert property (s_take(14'h3f00, 14'h0d00) |-> ##2
    carry_flag == $past(mem_rd_data[7]) && mem_wr_en == $past(instr_word[7], 2) &&
    $past({mem_rd_data[6:0], carry_flag}) == (mem_wr_en ? mem_wr_data : acc))
    else $error("rotate result wrong");
  chk_iret_load: assert property (s_take(14'h3fff, 14'h0009) |-> ##2
    stack_pop && global_irq_allow && prog_counter == $past(stack_top) &&
    $stable(zero_flag) && $stable(carry_flag)) else $error("return wrong");
  chk_nop_step: assert property (s_take(14'h3f9f, 14'h0000) |-> ##2
    prog_counter == $past(prog_counter, 2) + 13'h0001 && !mem_wr_en && $stable(acc))
    else $error("no-operation changed state");
endmodule // cmlse_assertions

bind cmlse_core cmlse_assertions chk_i (.ref_clk, .arst_n, .instr_valid, .instr_word,
  .instr_ready, .instr_done, .mem_rd_data, .mem_wr_en, .mem_wr_data, .stack_top,
  .stack_pop, .acc, .carry_flag, .zero_flag, .prog_counter, .global_irq_allow);

`default_nettype wire

// >>> core_move_logic_subset_exec_bench.sv
// Self-checking bench for the subset executor.
// Assumes cmlse_core with a checker bound; the bench models the register file.
`timescale 1ns/1ps
`default_nettype none

module core_move_logic_subset_exec_bench;
  logic ref_clk, arst_n, instr_valid, instr_ready, instr_done, instr_unsupported;
  logic mem_wr_en, stack_pop, carry_flag, zero_flag, global_irq_allow;
  logic [13:0] instr_word;
  logic [6:0] mem_addr;
  logic [7:0] mem_rd_data, mem_wr_data, acc;
  logic [12:0] stack_top, prog_counter, exp_pc;
  logic [7:0] mem [128];
  logic [38:0] row;
  int bad_count, n_tests;
  // Rows: word, acc, zero, carry, address, its byte afterwards
  localparam logic [38:0] ROWS [11] = '{
    {14'h33ff, 8'hff, 1'b0, 1'b0, 7'h7f, 8'h40},
    {14'h00ff, 8'hff, 1'b0, 1'b0, 7'h7f, 8'hff},
    {14'h0885, 8'hff, 1'b1, 1'b0, 7'h05, 8'h00},
    {14'h3000, 8'h00, 1'b1, 1'b0, 7'h05, 8'h00},
    {14'h0406, 8'h81, 1'b0, 1'b0, 7'h06, 8'h81},
    {14'h0d86, 8'h81, 1'b0, 1'b1, 7'h06, 8'h02},
    {14'h0d06, 8'h05, 1'b0, 1'b0, 7'h06, 8'h02},
    {14'h0486, 8'h05, 1'b0, 1'b0, 7'h06, 8'h07},
    {14'h0806, 8'h07, 1'b0, 1'b0, 7'h06, 8'h07},
    {14'h0060, 8'h07, 1'b0, 1'b0, 7'h06, 8'h07},
    {14'h0805, 8'h00, 1'b1, 1'b0, 7'h05, 8'h00}
  };

  cmlse_core dut (.ref_clk, .arst_n, .instr_valid, .instr_word, .instr_ready, .instr_done,
    .instr_unsupported, .mem_addr, .mem_rd_data, .mem_wr_en, .mem_wr_data, .stack_top,
    .stack_pop, .acc, .carry_flag, .zero_flag, .prog_counter, .global_irq_allow);

  // ****************************************
  // Register file model and helpers
  // ****************************************
  assign mem_rd_data = mem[mem_addr];
  always @(posedge ref_clk) begin
    if (mem_wr_en) mem[mem_addr] <= mem_wr_data;
  end

  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Offer one word at a falling edge, wait for retirement under a bound
  task automatic run(input logic [13:0] w);
    int i;
    instr_valid = 1'b1;
    instr_word = w;
    @(negedge ref_clk);
    instr_valid = 1'b0;
    instr_word = ~w;  // Stale word after the take must not matter
    chk(instr_ready, 13'h0000);
    for (i = 0; i < 8 && instr_done !== 1'b1; i++) @(negedge ref_clk);
    chk(instr_done, 13'h0001);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Watchdog, far beyond the few dozen cycles the tests need
  initial begin
    #(50 * 400);
    bad_count++;
    end_of_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    arst_n = 1'b0;
    instr_valid = 1'b0;
    instr_word = 14'h0000;
    stack_top = 13'h0abc;
    foreach (mem[i]) mem[i] = 8'h00;
    mem[6] = 8'h81;
    mem[127] = 8'h40;
    repeat (3) @(negedge ref_clk);
    arst_n = 1'b1;
    exp_pc = 13'h0000;
    foreach (ROWS[r]) begin
      row = ROWS[r];
      run(row[38:25]);
      exp_pc = exp_pc + 13'h0001;
      chk(acc, row[24:17]);
      chk(zero_flag, row[16]);
      chk(carry_flag, row[15]);
      chk(prog_counter, exp_pc);
      chk(instr_unsupported, 13'h0000);
      @(negedge ref_clk);
      chk(mem[row[14:8]], row[7:0]);
    end
    // Return from interrupt: counter from stack, interrupts allowed
    run(14'h0009);
    chk(stack_pop, 13'h0001);
    chk(prog_counter, 13'h0abc);
    chk(global_irq_allow, 13'h0001);
    chk(zero_flag, 13'h0001);
    chk(carry_flag, 13'h0000);
    @(negedge ref_clk);
    // Word outside the subset retires as a no-operation
    run(14'h3fff);
    chk(instr_unsupported, 13'h0001);
    chk(acc, 13'h0000);
    chk(zero_flag, 13'h0001);
    chk(prog_counter, 13'h0abd);
    chk(stack_pop, 13'h0000);
    @(negedge ref_clk);
    // Reset in mid-run, then a load at the first allowed edge
    arst_n = 1'b0;
    @(negedge ref_clk);
    chk(global_irq_allow, 13'h0000);
    chk(prog_counter, 13'h0000);
    chk(acc, 13'h0000);
    chk(zero_flag, 13'h0000);
    chk(instr_ready, 13'h0001);
    arst_n = 1'b1;
    run(14'h30a5);
    chk(acc, 13'h00a5);
    chk(prog_counter, 13'h0001);
    end_of_test();
  end
endmodule // core_move_logic_subset_exec_bench

`default_nettype wire
